/* src/oscsc_defs.vh */
// Constants for the oscillator source control block
`ifndef OSCSC_DEFS_VH
`define OSCSC_DEFS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OSCSC_HF_CTRL_ADDR 12'h000
`define OSCSC_LF_CTRL_ADDR 12'h004
`define OSCSC_MODE_ADDR 12'h008
// ****************************************
// Field positions
// ****************************************
`define OSCSC_HF_KEEP_RET_BIT 7
`define OSCSC_HF_EXT_DIG_BIT 6
`define OSCSC_HF_START_HI 5
`define OSCSC_HF_START_LO 4
`define OSCSC_HF_SRC_BIT 3
`define OSCSC_LF_READY_BIT 6
`define OSCSC_LF_SRC_HI 2
`define OSCSC_LF_SRC_LO 0
// ****************************************
// Reset values and encodings
// ****************************************
`define OSCSC_HF_CTRL_RST 8'h00
`define OSCSC_LF_SRC_RST 3'h1
`define OSCSC_HF_START_BOTH 2'h0
`define OSCSC_HF_START_RC 2'h1
`define OSCSC_HF_START_XO 2'h2
`define OSCSC_LF_XTAL 3'h0
`define OSCSC_LF_RC 3'h1
`define OSCSC_LF_SYNTH 3'h2
`define OSCSC_LF_EXT_ANA 3'h3
`define OSCSC_LF_EXT_DIG 3'h4
// ****************************************
// System modes
// ****************************************
`define OSCSC_MODE_DEEP_SLEEP 3'h0
`define OSCSC_MODE_MEM_RET_OFF 3'h1
`define OSCSC_MODE_MEM_RET_ON 3'h2
`define OSCSC_MODE_REG_RET 3'h3
`define OSCSC_MODE_STANDBY 3'h4
`define OSCSC_MODE_ACTIVE 3'h5
// ****************************************
// Timing in MCLK cycles (25 MHz)
// ****************************************
`define OSCSC_SETTLE_CYC 16'h0040
`endif

/* src/oscsc_ahb.v */
// AHB-Lite slave front end for the oscillator source control block
`timescale 1ns/1ps
module oscsc_ahb (
    // Clock and reset
    input wire MCLK,
    input wire RST,
    input wire CE,
    // AHB-Lite
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire HREADY,
    output wire HREADYOUT,
    output wire HRESP,
    // Register side
    output reg wr_en,
    output wire rd_en,
    output reg [11:0] reg_addr
);
// ****************************************
// Address phase capture
// ****************************************
wire take = HSEL & HTRANS[1] & HREADY;
assign HREADYOUT = 1'b1;
assign HRESP = 1'b0;
// Read strobe in the address phase so read data stands in the data phase
assign rd_en = take & ~HWRITE;
always @(posedge MCLK) begin
    if (RST) begin
        wr_en <= 1'b0;
        reg_addr <= 12'h000;
    end else if (CE) begin
        wr_en <= take & HWRITE;
        if (take) begin
            reg_addr <= HADDR[11:0];
        end
    end
end
endmodule

/* src/oscsc_top.v */
// Oscillator source control: HF/LF clock source selection and sequencing
// How it works
// RQ1 - The HF crystal runs only in active or standby unless keep bit 7 also keeps it in retention; the code honours the keep bit in register retention only.
// RQ2 - Firmware should keep the crystal on in retention when waking within 5 ms.
// RQ3 - By default both HF oscillators start together and RC supplies the clock first.
// RQ4 - After the crystal settles the clock switches to it and the RC is turned off.
// RQ5 - Bit 3 of the HF control reads which oscillator drives the high-speed clock.
// RQ6 - Bits 5:4 of the HF control let only one HF oscillator be started.
// RQ7 - Firmware must not use the radio while the HF clock comes from the RC.
// RQ8 - Bit 6 selects a digital external HF clock for test only and must be clear normally.
// RQ9 - An analog external HF clock needs bit 6 clear and bits 5:4 set to 10.
// RQ10 - LF source 000 enables the LF crystal, off in deep sleep and memory retention timer off.
// RQ11 - With the LF crystal enabled, port pins 0.0 and 0.1 become crystal pins.
// RQ12 - Bit 6 of the LF control reads ready when the chosen LF source is usable.
// RQ13 - LF source 001 enables the LF RC and releases pins 0.0 and 0.1.
// RQ14 - LF source 010 synthesises LF from the HF crystal in retention, standby or active; the code allows only register retention with bit 7 set.
// RQ15 - LF source 100 selects a digital and 011 an analog external clock on pin 0.1.
// RQ16 - Codes 101 to 111 in the LF source field are undefined and should not be written.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "oscsc_defs.vh"
module oscsc_top (
    // Clock and reset
    input wire MCLK,
    input wire RST,
    input wire CE,
    // AHB-Lite
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire HREADY,
    input wire [31:0] HWDATA,
    output wire HREADYOUT,
    output wire HRESP,
    output reg [31:0] HRDATA,
    // Oscillator status inputs
    input wire HF_XO_STABLE,
    input wire LF_XO_STABLE,
    input wire LF_RC_STABLE,
    // Oscillator controls
    output reg HF_XO_EN,
    output reg HF_RC_EN,
    output reg HF_SRC_XO,
    output reg HF_EXT_DIG,
    output reg LF_XO_EN,
    output reg LF_RC_EN,
    output reg LF_SYNTH_EN,
    output reg LF_EXT_EN,
    output reg LF_EXT_ANALOG,
    output reg P0_XTAL_MODE
);
// ****************************************
// Bus slave
// ****************************************
wire wr_en;
wire rd_en;
wire [11:0] reg_addr;
oscsc_ahb i_oscsc_ahb (
    .MCLK(MCLK),
    .RST(RST),
    .CE(CE),
    .HSEL(HSEL),
    .HADDR(HADDR),
    .HTRANS(HTRANS),
    .HWRITE(HWRITE),
    .HSIZE(HSIZE),
    .HREADY(HREADY),
    .HREADYOUT(HREADYOUT),
    .HRESP(HRESP),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .reg_addr(reg_addr)
);
// ****************************************
// Registers
// ****************************************
reg keep_ret;
reg ext_dig;
reg [1:0] hf_start;
reg [2:0] lf_src;
reg [2:0] sys_mode;
reg lf_ready;
reg [15:0] settle_cnt;
reg [1:0] hf_state;
localparam HF_OFF = 2'b00;
localparam HF_RC = 2'b01;
localparam HF_XO = 2'b10;
function is_hf_mode;
    input [2:0] m;
    begin
        is_hf_mode = (m == `OSCSC_MODE_ACTIVE) || (m == `OSCSC_MODE_STANDBY);
    end
endfunction
// HF crystal allowed to run in present mode
wire hf_run = is_hf_mode(sys_mode) ||
    (keep_ret && (sys_mode == `OSCSC_MODE_REG_RET)); // [RQ1]
wire lf_xo_mode = (sys_mode != `OSCSC_MODE_DEEP_SLEEP) &&
    (sys_mode != `OSCSC_MODE_MEM_RET_OFF); // [RQ10]
always @(posedge MCLK) begin
    if (RST) begin
        keep_ret <= 1'b0;
        ext_dig <= 1'b0;
        hf_start <= `OSCSC_HF_START_BOTH;
        lf_src <= `OSCSC_LF_SRC_RST;
        sys_mode <= `OSCSC_MODE_ACTIVE;
    end else if (CE && wr_en) begin
        case (reg_addr)
            `OSCSC_HF_CTRL_ADDR: begin
                keep_ret <= HWDATA[`OSCSC_HF_KEEP_RET_BIT]; // [RQ1]
                ext_dig <= HWDATA[`OSCSC_HF_EXT_DIG_BIT]; // [RQ8]
                hf_start <= HWDATA[`OSCSC_HF_START_HI:`OSCSC_HF_START_LO]; // [RQ6]
            end
            `OSCSC_LF_CTRL_ADDR: begin
                lf_src <= HWDATA[`OSCSC_LF_SRC_HI:`OSCSC_LF_SRC_LO];
            end
            `OSCSC_MODE_ADDR: begin
                sys_mode <= HWDATA[2:0];
            end
            default: begin
                sys_mode <= sys_mode;
            end
        endcase
    end
end
// ****************************************
// HF sequencing
// ****************************************
always @(posedge MCLK) begin
    if (RST) begin
        hf_state <= HF_OFF;
        settle_cnt <= 16'h0000;
        HF_XO_EN <= 1'b0;
        HF_RC_EN <= 1'b0;
        HF_SRC_XO <= 1'b0;
        HF_EXT_DIG <= 1'b0;
    end else if (CE) begin
        HF_EXT_DIG <= ext_dig; // [RQ8]
        case (hf_state)
            HF_OFF: begin
                settle_cnt <= 16'h0000;
                HF_SRC_XO <= 1'b0;
                if (hf_run) begin
                    hf_state <= (hf_start == `OSCSC_HF_START_XO) ? HF_XO : HF_RC;
                    // Both start together by default, RC clocks first
                    HF_XO_EN <= (hf_start != `OSCSC_HF_START_RC); // [RQ3] [RQ6] [RQ9]
                    HF_RC_EN <= (hf_start != `OSCSC_HF_START_XO); // [RQ3] [RQ6]
                end
            end
            HF_RC: begin
                if (!hf_run) begin
                    hf_state <= HF_OFF;
                    HF_XO_EN <= 1'b0;
                    HF_RC_EN <= 1'b0;
                end else if (HF_XO_EN && HF_XO_STABLE) begin
                    if (settle_cnt == `OSCSC_SETTLE_CYC) begin
                        hf_state <= HF_XO; // [RQ4]
                        HF_SRC_XO <= 1'b1; // [RQ4]
                        HF_RC_EN <= 1'b0; // [RQ4]
                    end else begin
                        settle_cnt <= settle_cnt + 16'h0001;
                    end
                end else begin
                    settle_cnt <= 16'h0000;
                end
            end
            HF_XO: begin
                HF_XO_EN <= hf_run;
                HF_SRC_XO <= hf_run;
                HF_RC_EN <= 1'b0;
                if (!hf_run) begin
                    hf_state <= HF_OFF;
                end
            end
            default: begin
                hf_state <= HF_OFF;
            end
        endcase
    end
end
// ****************************************
// LF source selection
// ****************************************
always @(posedge MCLK) begin
    if (RST) begin
        LF_XO_EN <= 1'b0;
        LF_RC_EN <= 1'b0;
        LF_SYNTH_EN <= 1'b0;
        LF_EXT_EN <= 1'b0;
        LF_EXT_ANALOG <= 1'b0;
        P0_XTAL_MODE <= 1'b0;
        lf_ready <= 1'b0;
    end else if (CE) begin
        LF_XO_EN <= (lf_src == `OSCSC_LF_XTAL) && lf_xo_mode; // [RQ10]
        P0_XTAL_MODE <= (lf_src == `OSCSC_LF_XTAL); // [RQ11] [RQ13]
        LF_RC_EN <= (lf_src == `OSCSC_LF_RC); // [RQ13]
        LF_SYNTH_EN <= (lf_src == `OSCSC_LF_SYNTH) && hf_run; // [RQ14]
        LF_EXT_EN <= (lf_src == `OSCSC_LF_EXT_DIG) ||
            (lf_src == `OSCSC_LF_EXT_ANA); // [RQ15]
        LF_EXT_ANALOG <= (lf_src == `OSCSC_LF_EXT_ANA); // [RQ15]
        case (lf_src)
            `OSCSC_LF_XTAL: lf_ready <= LF_XO_EN && LF_XO_STABLE; // [RQ12]
            `OSCSC_LF_RC: lf_ready <= LF_RC_EN && LF_RC_STABLE; // [RQ12]
            `OSCSC_LF_SYNTH: lf_ready <= LF_SYNTH_EN && HF_SRC_XO; // [RQ12]
            `OSCSC_LF_EXT_ANA: lf_ready <= LF_EXT_EN;
            `OSCSC_LF_EXT_DIG: lf_ready <= LF_EXT_EN;
            default: lf_ready <= 1'b0;
        endcase
    end
end
// ****************************************
// Read data
// ****************************************
always @(posedge MCLK) begin
    if (RST) begin
        HRDATA <= 32'h00000000;
    end else if (CE && rd_en) begin
        case (HADDR[11:0])
            `OSCSC_HF_CTRL_ADDR: begin
                HRDATA <= {24'h000000, keep_ret, ext_dig, hf_start,
                    HF_SRC_XO, 3'h0}; // [RQ5]
            end
            `OSCSC_LF_CTRL_ADDR: begin
                HRDATA <= {24'h000000, 1'b0, lf_ready, 3'h0, lf_src}; // [RQ12]
            end
            `OSCSC_MODE_ADDR: begin
                HRDATA <= {29'h00000000, sys_mode};
            end
            default: begin
                HRDATA <= 32'h00000000;
            end
        endcase
    end
end
endmodule

/* verif/oscsc_osc_model.sv */
// Oscillator start-up model: flags stable a set delay after enable
`timescale 1ns/1ps
module oscsc_osc_model #(
    parameter DLY = 8
) (
    // Clock
    input wire clk,
    // Oscillator
    input wire en,
    output reg stable = 1'h0
);
    int cnt = 0;
    // Stable drops on the first clock after the enable goes away
    always @(posedge clk) begin
        cnt <= en ? ((cnt < DLY) ? cnt + 1 : cnt) : 0;
        stable <= en && (cnt >= DLY);
    end
endmodule

/* verif/oscsc_checker.sv */
// Checker for the oscillator source control block
`timescale 1ns/1ps
module oscsc_checker (
    // Clock and reset
    input wire MCLK,
    input wire RST,
    input wire CE,
    // Bus response
    input wire HREADYOUT,
    input wire HRESP,
    // Oscillator pins
    input wire HF_XO_STABLE,
    input wire HF_XO_EN,
    input wire HF_RC_EN,
    input wire HF_SRC_XO,
    input wire LF_XO_EN,
    input wire LF_RC_EN,
    input wire LF_SYNTH_EN,
    input wire LF_EXT_EN,
    input wire LF_EXT_ANALOG,
    input wire P0_XTAL_MODE
);
    reg [7:0] stable_cnt;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // ****************
    // Settle counter
    // ****************
    always @(posedge MCLK) begin
        if (RST || !HF_XO_STABLE)
            stable_cnt <= 8'h00;
        else if (CE && stable_cnt != 8'hFF)
            stable_cnt <= stable_cnt + 8'h01;
    end
    AST_RST_START: assert property ($fell(RST) |-> ##[1:3] (HF_XO_EN && HF_RC_EN && !HF_SRC_XO))
        else $error("both HF oscillators not started after reset");
    AST_SWITCH_SETTLED: assert property ($rose(HF_SRC_XO) && $past(HF_RC_EN) |-> stable_cnt >= 8'h40)
        else $error("switch to crystal before settle time");
    AST_RC_OFF: assert property ($rose(HF_SRC_XO) |-> HF_XO_EN ##1 !HF_RC_EN)
        else $error("RC still on after switch to crystal");
    AST_LF_ONE: assert property ($onehot0({LF_XO_EN, LF_RC_EN, LF_SYNTH_EN, LF_EXT_EN}))
        else $error("more than one LF source enabled");
    AST_XTAL_PINS: assert property (LF_XO_EN |-> P0_XTAL_MODE)
        else $error("LF crystal on without crystal pins");
    AST_PINS_FREE: assert property (LF_RC_EN |-> !P0_XTAL_MODE)
        else $error("pins held as crystal pins with LF RC");
    AST_EXT_KIND: assert property (LF_EXT_ANALOG |-> LF_EXT_EN)
        else $error("analog external LF without external select");
    AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
        else $error("bus response not ready and okay");
    cover property ($rose(HF_SRC_XO));
    cover property ($rose(LF_EXT_ANALOG));
    cover property ($rose(P0_XTAL_MODE));
endmodule
bind oscsc_top oscsc_checker i_oscsc_checker (.MCLK(MCLK), .RST(RST), .CE(CE),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HF_XO_STABLE(HF_XO_STABLE), .HF_XO_EN(HF_XO_EN),
    .HF_RC_EN(HF_RC_EN), .HF_SRC_XO(HF_SRC_XO), .LF_XO_EN(LF_XO_EN), .LF_RC_EN(LF_RC_EN),
    .LF_SYNTH_EN(LF_SYNTH_EN), .LF_EXT_EN(LF_EXT_EN), .LF_EXT_ANALOG(LF_EXT_ANALOG),
    .P0_XTAL_MODE(P0_XTAL_MODE));

/* verif/tb_oscsc_top.sv */
// Self-checking testbench for the oscillator source control block
`timescale 1ns/1ps
`include "oscsc_defs.vh"
module tb_oscsc_top;
    reg MCLK = 0;
    reg RST = 1;
    reg HSEL = 0;
    reg HWRITE = 0;
    reg rdp = 0;
    reg pnp = 0;
    reg [1:0] HTRANS = 0;
    reg [31:0] HADDR = 0;
    reg [31:0] HWDATA = 0;
    reg [31:0] r;
    wire HREADYOUT, HRESP, hxs, lxs, lrs;
    wire [31:0] HRDATA;
    wire [3:0] hf;
    wire [5:0] lf;
    logic [63:0] exq[$];
    logic [63:0] ex;
    logic [5:0] lx[5] = '{6'h21, 6'h10, 6'h08, 6'h06, 6'h04};
    int err_total = 0;
    int samples_checked = 0;
    int i;
    oscsc_top i_oscsc_top (.MCLK(MCLK), .RST(RST), .CE(1'h1), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA(HWDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .HF_XO_STABLE(hxs),
        .LF_XO_STABLE(lxs), .LF_RC_STABLE(lrs), .HF_XO_EN(hf[3]), .HF_RC_EN(hf[2]),
        .HF_SRC_XO(hf[1]), .HF_EXT_DIG(hf[0]), .LF_XO_EN(lf[5]), .LF_RC_EN(lf[4]),
        .LF_SYNTH_EN(lf[3]), .LF_EXT_EN(lf[2]), .LF_EXT_ANALOG(lf[1]), .P0_XTAL_MODE(lf[0]));
    oscsc_osc_model #(.DLY(20)) i_oscsc_osc_model_hx (.clk(MCLK), .en(hf[3]), .stable(hxs));
    oscsc_osc_model #(.DLY(30)) i_oscsc_osc_model_lx (.clk(MCLK), .en(lf[5]), .stable(lxs));
    oscsc_osc_model #(.DLY(5)) i_oscsc_osc_model_lr (.clk(MCLK), .en(lf[4]), .stable(lrs));
    initial forever #20 MCLK = ~MCLK;
    task cmp_rd(input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED read expected %h seen %h", e, g);
        end
    endtask
    task cmp_pin(input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED pins expected %h seen %h", e, g);
        end
    endtask
    // Result watcher: oldest note against the value seen
    always @(posedge MCLK) begin
        if (rdp || pnp) begin
            ex = exq.pop_front();
            if (rdp)
                cmp_rd(ex[31:0], HRDATA & ex[63:32]);
            else
                cmp_pin(ex[31:0], {22'h0, hf, lf} & ex[63:32]);
        end
    end
    task bus(input bit w, input [31:0] a, input [31:0] d);
        @(posedge MCLK);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= a;
        @(posedge MCLK);
        while (!HREADYOUT) @(posedge MCLK);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rdp <= !w;
        @(posedge MCLK);
        while (!HREADYOUT) @(posedge MCLK);
        rdp <= 1'h0;
    endtask
    task rd(input [31:0] a, input [31:0] e, input [31:0] m);
        exq.push_back({m, e});
        bus(1'h0, a, 32'h0);
    endtask
    task pins(input [9:0] e, input [9:0] m);
        exq.push_back({22'h0, m, 22'h0, e});
        pnp <= 1'h1;
        @(posedge MCLK);
        pnp <= 1'h0;
    endtask
    task step(input [7:0] h, input [2:0] l, input [2:0] m, input [9:0] e, input [9:0] k);
        bus(1'h1, `OSCSC_HF_CTRL_ADDR, {24'h0, h});
        bus(1'h1, `OSCSC_LF_CTRL_ADDR, {29'h0, l});
        bus(1'h1, `OSCSC_MODE_ADDR, {29'h0, m});
        repeat (3) @(posedge MCLK);
        pins(e, k);
    endtask
    task wrap_up;
        $display("Compared %0d, mismatched %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge MCLK);
        err_total++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'hB434));
        repeat (10) @(posedge MCLK);
        RST <= 1'h0;
        repeat (3) @(posedge MCLK);
        pins(10'h310, 10'h3FF);
        rd(`OSCSC_HF_CTRL_ADDR, 32'h0, 32'hFFFFFFFF);
        for (i = 0; i < 400 && hf[1] !== 1'h1; i++) @(posedge MCLK);
        pins(10'h290, 10'h3FF);
        rd(`OSCSC_HF_CTRL_ADDR, 32'h08, 32'hFFFFFFFF);
        rd(`OSCSC_LF_CTRL_ADDR, 32'h41, 32'hFFFFFFFF);
        step(8'h00, 3'h1, 3'h4, 10'h200, 10'h200);
        step(8'h00, 3'h1, 3'h3, 10'h000, 10'h200);
        step(8'h80, 3'h1, 3'h3, 10'h200, 10'h200);
        step(8'h80, 3'h1, 3'h2, 10'h000, 10'h200);
        for (i = 0; i < 3; i++) begin
            step({2'h0, i[1:0], 4'h0}, 3'h1, 3'h0, 10'h000, 10'h380);
            step({2'h0, i[1:0], 4'h0}, 3'h1, 3'h5, {i != 1, i != 2, i == 2, 7'h00}, 10'h380);
        end
        step(8'h00, 3'h0, 3'h1, 10'h000, 10'h020);
        step(8'h00, 3'h0, 3'h2, 10'h021, 10'h021);
        step(8'h00, 3'h2, 3'h2, 10'h000, 10'h008);
        step(8'h80, 3'h2, 3'h3, 10'h008, 10'h008);
        for (i = 0; i < 5; i++) begin
            step(8'h00, i[2:0], 3'h5, {4'h0, lx[i]}, 10'h03F);
            rd(`OSCSC_LF_CTRL_ADDR, i, 32'hFFFFFFBF);
        end
        step(8'h00, 3'h0, 3'h5, 10'h021, 10'h03F);
        repeat (40) @(posedge MCLK);
        rd(`OSCSC_LF_CTRL_ADDR, 32'h40, 32'hFFFFFFFF);
        r = $urandom;
        bus(1'h1, `OSCSC_HF_CTRL_ADDR, {r[31:8], 8'h40});
        repeat (3) @(posedge MCLK);
        pins(10'h041, 10'h041);
        rd(`OSCSC_HF_CTRL_ADDR, 32'h40, 32'hFFFFFFF7);
        bus(1'h1, `OSCSC_HF_CTRL_ADDR, 32'h0);
        bus(1'h1, {26'h0, 2'h1, r[1:0], 2'h0}, r);
        rd({26'h0, 2'h1, r[1:0], 2'h0}, 32'h0, 32'hFFFFFFFF);
        rd(`OSCSC_HF_CTRL_ADDR, 32'h0, 32'hFFFFFFF7);
        wrap_up;
    end
endmodule
